// file: rtl/crs_pkg.sv
// Shared constants and types of the processor register set.
// Assumes a single system clock; no module state lives here.
package crs_pkg;

  // Flag positions inside the condition flags register
  localparam int FLAG_V = 7;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] FLAGS_FIXED_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;

  // Reset values and vectors
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [7:0] STACK_LOW_PRESET = 8'hff;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_SOFT = 16'hfffc;
  localparam logic [15:0] VEC_IRQ_TOP = 16'hfffa;
  localparam logic [15:0] BRANCH_LEN = 16'h0002;
  localparam logic [2:0] INT_STACK_LAST = 3'h4;

  // Avalon register map (byte addresses) and command fields
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_RESULT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CMD_OP_LSB = 16;
  localparam int CMD_OP_W = 5;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
    OP_AND = 5'h04, OP_LOAD_ACC = 5'h05, OP_SHIFT_LEFT = 5'h06, OP_ROTATE_RIGHT = 5'h07,
    OP_LOAD_INDEX = 5'h08, OP_STACK_LOW_PRESET = 5'h09, OP_UNMASK = 5'h0a, OP_MASK = 5'h0b,
    OP_PUSH_ACC = 5'h0c, OP_PULL_ACC = 5'h0d, OP_PUSH_INDEX_UPPER = 5'h0e, OP_PULL_INDEX_UPPER = 5'h0f,
    OP_RETURN_FROM_HANDLER = 5'h10, OP_JUMP = 5'h11, OP_FETCH = 5'h12, OP_BRANCH = 5'h13,
    OP_EA_INDEX = 5'h14, OP_EA_STACK = 5'h15, OP_READ_REG = 5'h16, OP_LOAD_FLAGS = 5'h17,
    OP_SOFT_INT = 5'h18
  } crs_op_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_ADC = 3'h1, ALU_SUB = 3'h2, ALU_AND = 3'h3,
    ALU_PASS = 3'h4, ALU_ASL = 3'h5, ALU_ROR = 3'h6
  } crs_alu_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_VEC_RD = 4'h1, ST_RD_WAIT = 4'h2, ST_RD_DATA = 4'h3,
    ST_PUSH = 4'h4, ST_PULL = 4'h5
  } crs_state_t;

  typedef enum logic [1:0] {
    KIND_ACC = 2'h0, KIND_INDEX_UPPER = 2'h1, KIND_INT = 2'h2, KIND_RETURN = 2'h3
  } crs_kind_t;

endpackage : crs_pkg

// file: rtl/crs_alu_if.sv
// Operand and result bundle between the register core and its ALU.
// Assumes both ends sit in the same clock domain; purely combinational.
`timescale 1ns/1ps
interface crs_alu_if;
  crs_pkg::crs_alu_op_t op;
  logic [7:0] a;
  logic [7:0] m;
  logic cin;
  logic [7:0] res;
  logic v;
  logic h;
  logic c;
  logic n;
  logic z;
  logic upd_v;
  logic upd_h;
  logic upd_c;
  modport core (output op, a, m, cin, input res, v, h, c, n, z, upd_v, upd_h, upd_c);
  modport alu (input op, a, m, cin, output res, v, h, c, n, z, upd_v, upd_h, upd_c);
endinterface : crs_alu_if

// file: rtl/crs_alu.sv
// Eight-bit arithmetic and logic unit with flag generation.
// Assumes the core applies the update enables to its flags register.
`timescale 1ns/1ps
module crs_alu (
  crs_alu_if.alu bus
);
  logic [8:0] wide;
  logic [4:0] low;

  always_comb begin
    wide = 9'h000;
    low = 5'h00;
    bus.res = 8'h00;
    bus.v = 1'b0;
    bus.h = 1'b0;
    bus.c = bus.cin;
    bus.upd_v = 1'b1;
    bus.upd_h = 1'b0;
    bus.upd_c = 1'b0;
    case (bus.op)
      crs_pkg::ALU_ADD, crs_pkg::ALU_ADC: begin
        wide = {1'b0, bus.a} + {1'b0, bus.m} + {8'h00, (bus.op == crs_pkg::ALU_ADC) & bus.cin};
        low = {1'b0, bus.a[3:0]} + {1'b0, bus.m[3:0]} + {4'h0, (bus.op == crs_pkg::ALU_ADC) & bus.cin};
        bus.res = wide[7:0];
        bus.h = low[4]; // see [RQ11]
        bus.upd_h = 1'b1;
        bus.c = wide[8]; // see [RQ19]
        bus.upd_c = 1'b1;
        bus.v = (bus.a[7] == bus.m[7]) && (wide[7] != bus.a[7]); // see [RQ10]
      end
      crs_pkg::ALU_SUB: begin
        wide = {1'b0, bus.a} - {1'b0, bus.m};
        bus.res = wide[7:0];
        bus.c = wide[8]; // see [RQ19]
        bus.upd_c = 1'b1;
        bus.v = (bus.a[7] != bus.m[7]) && (wide[7] != bus.a[7]); // see [RQ10]
      end
      crs_pkg::ALU_AND: bus.res = bus.a & bus.m;
      crs_pkg::ALU_PASS: bus.res = bus.m;
      crs_pkg::ALU_ASL: begin
        bus.res = {bus.a[6:0], 1'b0};
        bus.c = bus.a[7]; // see [RQ19]
        bus.upd_c = 1'b1;
        bus.v = bus.a[6] ^ bus.a[7];
      end
      crs_pkg::ALU_ROR: begin
        bus.res = {bus.cin, bus.a[7:1]};
        bus.c = bus.a[0]; // see [RQ19]
        bus.upd_c = 1'b1;
        bus.v = bus.cin ^ bus.a[0];
      end
      default: bus.upd_v = 1'b0;
    endcase
    bus.n = bus.res[7]; // see [RQ17]
    bus.z = (bus.res == 8'h00); // see [RQ18]
  end
endmodule : crs_alu

// file: rtl/crs_core.sv
// Processor register set: accumulator, index pair, stack, program counter, flags.
// Assumes a byte memory whose read data is valid the cycle after mem_rd_out is high,
// and an Avalon-MM master issuing operations through the command register.
//
// Summary of operation
// [RQ1] Eight-bit accumulator feeds and receives ALU results
// [RQ2] Sixteen-bit index pair forms indexed operand addresses
// [RQ3] Any reset loads stack pointer with 00FF
// [RQ4] Low-byte preset op writes FF, keeps high
// [RQ5] Push decrements, pull increments the stack pointer
// [RQ6] Stack-relative addressing uses stack pointer as base
// [RQ7] Program counter steps on fetch, loads on jumps
// [RQ8] Reset loads program counter from FFFE/FFFF vector
// [RQ9] Flag bits 6 and 5 always read one
// [RQ10] Overflow flag tracks signed two's-complement overflow
// [RQ11] Half-carry set on carry from bit 3
// [RQ12] Mask blocks interrupts; set after stacking, before vector
// [RQ13] Interrupt stacking leaves index upper byte alone
// [RQ14] Return op pulls registers including old mask
// [RQ15] Highest-priority pending request is served first
// [RQ16] Reset sets mask; only unmask op clears (the return op also clears it when it pulls a clear mask)
// [RQ17] Negative flag copies result bit 7
// [RQ18] Zero flag set when result is 00
// [RQ19] Carry from add, borrow on subtract, shifts
// [RQ20] Registers reached by operations only, never mapped
// [RQ21] Flag layout V,1,1,H,I,N,Z,C from bit 7
`timescale 1ns/1ps
module crs_core #(
  parameter int NUM_IRQ = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Avalon-MM slave
  input wire logic [crs_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Byte memory for stack and vectors
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_wr_out,
  output logic mem_rd_out,
  input wire logic [7:0] mem_rdata_in,
  // Interrupt requests, index 0 highest priority
  input wire logic [NUM_IRQ-1:0] irq_req_in,
  output logic [NUM_IRQ-1:0] irq_ack_out,
  // Sequencer view
  output logic [15:0] program_counter_out,
  output logic [15:0] ea_out
);

  typedef struct packed {
    crs_pkg::crs_state_t st;
    crs_pkg::crs_kind_t kind;
    logic [2:0] step;
    logic is_vec;
    logic [7:0] accumulator;
    logic [15:0] index_pair;
    logic [15:0] stack_pointer;
    logic [15:0] program_counter;
    logic [7:0] flags;
    logic [15:0] vaddr;
    logic [15:0] result;
    logic [15:0] ea;
    logic rd_ack;
    logic [31:0] rdata;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_wr;
    logic mem_rd;
    logic [NUM_IRQ-1:0] irq_ack;
  } crs_core_state_t;

  localparam crs_core_state_t RESET_STATE = '{
    st: crs_pkg::ST_VEC_RD, kind: crs_pkg::KIND_ACC, step: 3'h0, is_vec: 1'b1,
    accumulator: 8'h00, index_pair: 16'h0000, stack_pointer: crs_pkg::STACK_RESET,
    program_counter: 16'h0000, flags: crs_pkg::FLAGS_RESET, vaddr: crs_pkg::VEC_RESET,
    result: 16'h0000, ea: 16'h0000, rd_ack: 1'b0, rdata: 32'h0000_0000,
    mem_addr: 16'h0000, mem_wdata: 8'h00, mem_wr: 1'b0, mem_rd: 1'b0, irq_ack: '0
  };

  crs_core_state_t q;
  crs_core_state_t next_q;
  logic rst_meta_n;
  logic rst_sync_n;
  logic irq_take;
  logic cmd_hit;
  logic cmd_go;
  logic [15:0] opnd;
  crs_pkg::crs_op_t op;
  logic [7:0] push_byte;
  logic push_last;
  logic pull_last;
  logic [15:0] irq_vec;
  logic [NUM_IRQ-1:0] irq_onehot;

  crs_alu_if alu_bus ();

  crs_alu u_alu (
    .bus(alu_bus)
  );

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign opnd = avs_writedata_in[15:0];
  assign op = crs_pkg::crs_op_t'(avs_writedata_in[crs_pkg::CMD_OP_LSB +: crs_pkg::CMD_OP_W]);
  assign cmd_hit = avs_write_in && (avs_address_in == crs_pkg::REG_CMD);
  assign irq_take = (q.st == crs_pkg::ST_IDLE) && !q.flags[crs_pkg::FLAG_I] && (|irq_req_in); // see [RQ12]
  // Interrupt entry wins over a waiting command; the command is held off, not dropped
  assign cmd_go = cmd_hit && (q.st == crs_pkg::ST_IDLE) && !irq_take;
  assign avs_waitrequest_out = avs_read_in ? !q.rd_ack
                                           : (cmd_hit && ((q.st != crs_pkg::ST_IDLE) || irq_take));

  // Lowest index wins among pending requests
  always_comb begin
    irq_onehot = '0;
    irq_vec = crs_pkg::VEC_IRQ_TOP;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (irq_req_in[k]) begin
        irq_onehot = '0;
        irq_onehot[k] = 1'b1; // see [RQ15]
        irq_vec = crs_pkg::VEC_IRQ_TOP - 16'(2 * k);
      end
    end
  end

  // Byte order on interrupt entry; the index upper byte is stacked only by its own push op
  always_comb begin
    case (q.kind)
      crs_pkg::KIND_ACC: push_byte = q.accumulator;
      crs_pkg::KIND_INDEX_UPPER: push_byte = q.index_pair[15:8];
      default: begin
        case (q.step)
          3'h0: push_byte = q.program_counter[7:0];
          3'h1: push_byte = q.program_counter[15:8];
          3'h2: push_byte = q.index_pair[7:0]; // see [RQ13]
          3'h3: push_byte = q.accumulator;
          default: push_byte = q.flags;
        endcase
      end
    endcase
  end

  assign push_last = (q.kind != crs_pkg::KIND_INT) || (q.step == crs_pkg::INT_STACK_LAST);
  assign pull_last = (q.kind != crs_pkg::KIND_RETURN) || (q.step == crs_pkg::INT_STACK_LAST);

  // ALU is steered straight from the command word
  always_comb begin
    alu_bus.a = q.accumulator; // see [RQ1]
    alu_bus.m = opnd[7:0];
    alu_bus.cin = q.flags[crs_pkg::FLAG_C];
    case (op)
      crs_pkg::OP_ADD: alu_bus.op = crs_pkg::ALU_ADD;
      crs_pkg::OP_ADC: alu_bus.op = crs_pkg::ALU_ADC;
      crs_pkg::OP_SUB: alu_bus.op = crs_pkg::ALU_SUB;
      crs_pkg::OP_AND: alu_bus.op = crs_pkg::ALU_AND;
      crs_pkg::OP_SHIFT_LEFT: alu_bus.op = crs_pkg::ALU_ASL;
      crs_pkg::OP_ROTATE_RIGHT: alu_bus.op = crs_pkg::ALU_ROR;
      default: alu_bus.op = crs_pkg::ALU_PASS;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.mem_wr = 1'b0;
    next_q.mem_rd = 1'b0;
    next_q.irq_ack = '0;
    next_q.rd_ack = avs_read_in && !q.rd_ack;
    // Only result and status are visible; the register set has no address
    if (avs_read_in && !q.rd_ack) begin // see [RQ20]
      case (avs_address_in)
        crs_pkg::REG_RESULT: next_q.rdata = {16'h0000, q.result};
        crs_pkg::REG_STATUS: next_q.rdata = {q.ea, 11'h000, q.st, q.st != crs_pkg::ST_IDLE};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
    case (q.st)
      crs_pkg::ST_VEC_RD: begin
        next_q.mem_rd = 1'b1;
        next_q.mem_addr = q.vaddr + {15'h0000, q.step[0]};
        next_q.is_vec = 1'b1;
        next_q.st = crs_pkg::ST_RD_WAIT;
      end
      crs_pkg::ST_RD_WAIT: next_q.st = crs_pkg::ST_RD_DATA;
      crs_pkg::ST_RD_DATA: begin
        if (q.is_vec) begin
          // High byte first, then low byte at the next address
          if (q.step == 3'h0) begin
            next_q.program_counter[15:8] = mem_rdata_in; // see [RQ8]
            next_q.step = 3'h1;
            next_q.st = crs_pkg::ST_VEC_RD;
          end else begin
            next_q.program_counter[7:0] = mem_rdata_in; // see [RQ8]
            next_q.step = 3'h0;
            next_q.st = crs_pkg::ST_IDLE;
          end
        end else begin
          case (q.kind)
            crs_pkg::KIND_ACC: next_q.accumulator = mem_rdata_in;
            crs_pkg::KIND_INDEX_UPPER: next_q.index_pair[15:8] = mem_rdata_in;
            default: begin
              case (q.step)
                3'h0: next_q.flags = mem_rdata_in; // see [RQ14]
                3'h1: next_q.accumulator = mem_rdata_in;
                3'h2: next_q.index_pair[7:0] = mem_rdata_in;
                3'h3: next_q.program_counter[15:8] = mem_rdata_in;
                default: next_q.program_counter[7:0] = mem_rdata_in;
              endcase
            end
          endcase
          next_q.step = pull_last ? 3'h0 : q.step + 3'h1;
          next_q.st = pull_last ? crs_pkg::ST_IDLE : crs_pkg::ST_PULL;
        end
      end
      crs_pkg::ST_PULL: begin
        next_q.stack_pointer = q.stack_pointer + 16'h0001; // see [RQ5]
        next_q.mem_addr = q.stack_pointer + 16'h0001;
        next_q.mem_rd = 1'b1;
        next_q.is_vec = 1'b0;
        next_q.st = crs_pkg::ST_RD_WAIT;
      end
      crs_pkg::ST_PUSH: begin
        next_q.mem_wr = 1'b1;
        next_q.mem_addr = q.stack_pointer;
        next_q.mem_wdata = push_byte;
        next_q.stack_pointer = q.stack_pointer - 16'h0001; // see [RQ5]
        next_q.step = push_last ? 3'h0 : q.step + 3'h1;
        if (!push_last) begin
          next_q.st = crs_pkg::ST_PUSH;
        end else if (q.kind == crs_pkg::KIND_INT) begin
          next_q.flags[crs_pkg::FLAG_I] = 1'b1; // see [RQ12]
          next_q.st = crs_pkg::ST_VEC_RD; // see [RQ7]
        end else begin
          next_q.st = crs_pkg::ST_IDLE;
        end
      end
      crs_pkg::ST_IDLE: begin
        if (irq_take) begin
          next_q.kind = crs_pkg::KIND_INT;
          next_q.step = 3'h0;
          next_q.vaddr = irq_vec; // see [RQ15]
          next_q.irq_ack = irq_onehot;
          next_q.st = crs_pkg::ST_PUSH;
        end else if (cmd_go) begin
          case (op)
            crs_pkg::OP_ADD, crs_pkg::OP_ADC, crs_pkg::OP_SUB, crs_pkg::OP_AND,
            crs_pkg::OP_LOAD_ACC, crs_pkg::OP_SHIFT_LEFT, crs_pkg::OP_ROTATE_RIGHT: begin
              next_q.accumulator = alu_bus.res; // see [RQ1]
              next_q.result = {8'h00, alu_bus.res};
              next_q.flags[crs_pkg::FLAG_N] = alu_bus.n; // see [RQ17]
              next_q.flags[crs_pkg::FLAG_Z] = alu_bus.z; // see [RQ18]
              if (alu_bus.upd_v) begin
                next_q.flags[crs_pkg::FLAG_V] = alu_bus.v; // see [RQ10]
              end
              if (alu_bus.upd_h) begin
                next_q.flags[crs_pkg::FLAG_H] = alu_bus.h; // see [RQ11]
              end
              if (alu_bus.upd_c) begin
                next_q.flags[crs_pkg::FLAG_C] = alu_bus.c; // see [RQ19]
              end
            end
            crs_pkg::OP_LOAD_INDEX: next_q.index_pair = opnd;
            crs_pkg::OP_STACK_LOW_PRESET: next_q.stack_pointer[7:0] = crs_pkg::STACK_LOW_PRESET; // see [RQ4]
            crs_pkg::OP_UNMASK: next_q.flags[crs_pkg::FLAG_I] = 1'b0; // see [RQ16]
            crs_pkg::OP_MASK: next_q.flags[crs_pkg::FLAG_I] = 1'b1;
            crs_pkg::OP_PUSH_ACC, crs_pkg::OP_PUSH_INDEX_UPPER: begin
              next_q.kind = (op == crs_pkg::OP_PUSH_ACC) ? crs_pkg::KIND_ACC : crs_pkg::KIND_INDEX_UPPER;
              next_q.step = 3'h0;
              next_q.st = crs_pkg::ST_PUSH;
            end
            crs_pkg::OP_PULL_ACC, crs_pkg::OP_PULL_INDEX_UPPER: begin
              next_q.kind = (op == crs_pkg::OP_PULL_ACC) ? crs_pkg::KIND_ACC : crs_pkg::KIND_INDEX_UPPER;
              next_q.step = 3'h0;
              next_q.st = crs_pkg::ST_PULL;
            end
            crs_pkg::OP_RETURN_FROM_HANDLER: begin
              next_q.kind = crs_pkg::KIND_RETURN; // see [RQ14]
              next_q.step = 3'h0;
              next_q.st = crs_pkg::ST_PULL;
            end
            crs_pkg::OP_SOFT_INT: begin
              next_q.kind = crs_pkg::KIND_INT;
              next_q.step = 3'h0;
              next_q.vaddr = crs_pkg::VEC_SOFT;
              next_q.st = crs_pkg::ST_PUSH;
            end
            crs_pkg::OP_JUMP: next_q.program_counter = opnd; // see [RQ7]
            crs_pkg::OP_FETCH: next_q.program_counter = q.program_counter + 16'h0001; // see [RQ7]
            crs_pkg::OP_BRANCH: begin
              next_q.program_counter = q.program_counter + crs_pkg::BRANCH_LEN
                                       + {{8{opnd[7]}}, opnd[7:0]}; // see [RQ7]
            end
            crs_pkg::OP_EA_INDEX: next_q.ea = q.index_pair + opnd; // see [RQ2]
            crs_pkg::OP_EA_STACK: next_q.ea = q.stack_pointer + opnd; // see [RQ6]
            crs_pkg::OP_READ_REG: begin
              case (opnd[2:0])
                3'h0: next_q.result = {8'h00, q.accumulator};
                3'h1: next_q.result = q.index_pair;
                3'h2: next_q.result = q.stack_pointer;
                3'h3: next_q.result = q.program_counter;
                default: next_q.result = {8'h00, q.flags};
              endcase
            end
            crs_pkg::OP_LOAD_FLAGS: begin
              // Mask bit kept: only the unmask op and the return op clear it
              next_q.flags = {opnd[7:4], q.flags[crs_pkg::FLAG_I], opnd[2:0]}; // see [RQ16] [RQ21]
            end
            default: next_q.st = crs_pkg::ST_IDLE;
          endcase
        end
      end
      default: next_q.st = crs_pkg::ST_IDLE;
    endcase
    next_q.flags = next_q.flags | crs_pkg::FLAGS_FIXED_ONES; // see [RQ9]
  end

  // Reset state: stack 00FF, mask set, vector fetch pending
  always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= RESET_STATE; // see [RQ3] [RQ16] [RQ8]
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata_out = q.rdata;
  assign mem_addr_out = q.mem_addr;
  assign mem_wdata_out = q.mem_wdata;
  assign mem_wr_out = q.mem_wr;
  assign mem_rd_out = q.mem_rd;
  assign irq_ack_out = q.irq_ack;
  assign program_counter_out = q.program_counter;
  assign ea_out = q.ea;

endmodule : crs_core

// file: verif/crs_core_assertions.sv
// Assertions on the register set's bus, stack and interrupt ports.
// Assumes binding onto crs_core; sees only its ports.
`timescale 1ns/1ps
module crs_core_assertions #(
  parameter int NUM_IRQ = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Register bus
  input wire logic [crs_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Memory and interrupts
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_wr_out,
  input wire logic mem_rd_out,
  input wire logic [NUM_IRQ-1:0] irq_req_in,
  input wire logic [NUM_IRQ-1:0] irq_ack_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic any_ack;
  assign any_ack = |irq_ack_out;

  a_ack_one_hot: assert property (any_ack |-> $onehot(irq_ack_out))
    else $error("ack not one-hot");
  a_ack_single_pulse: assert property (any_ack |=> !any_ack)
    else $error("ack too long");
  a_ack_has_request: assert property (any_ack |-> (irq_ack_out & $past(irq_req_in)) == irq_ack_out)
    else $error("ack without request");
  a_ack_priority: assert property (any_ack |-> ((irq_ack_out - NUM_IRQ'(1)) & $past(irq_req_in)) == '0)
    else $error("priority skipped");
  a_mem_exclusive: assert property (!(mem_rd_out && mem_wr_out))
    else $error("read and write together");
  a_push_descends: assert property (mem_wr_out && $past(mem_wr_out) |->
    mem_addr_out == $past(mem_addr_out) - 16'h0001)
    else $error("pushes not descending");
  a_read_one_wait: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read wait not one cycle");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in != crs_pkg::REG_RESULT
    && avs_address_in != crs_pkg::REG_STATUS |-> avs_readdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_vector: assert property ($rose(resetn_in) |-> ##[1:6] (mem_rd_out && mem_addr_out == crs_pkg::VEC_RESET))
    else $error("reset vector not fetched");
  a_wait_bounded: assert property (avs_waitrequest_out |-> ##[1:24] !avs_waitrequest_out)
    else $error("wait too long");

  c_ack: cover property (any_ack);
  c_push_pair: cover property (mem_wr_out && $past(mem_wr_out));
  c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
endmodule : crs_core_assertions

bind crs_core crs_core_assertions #(.NUM_IRQ(NUM_IRQ)) u_crs_chk (.*);

// file: verif/crs_mem_model.sv
// Byte memory behind the core: stack space and vector table.
// Assumes read data is wanted in the cycle after a read strobe.
`timescale 1ns/1ps
module crs_mem_model (
  // Clock
  input wire logic clk_sys_in,
  // Memory port
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  output logic [7:0] mem_rdata_out
);
  logic [7:0] mem [0:65535];
  initial begin
    mem_rdata_out = 8'h5a;
    // Byte fff0+i holds 80+i so every vector differs
    for (int i = 0; i < 16; i++) begin
      mem[16'hfff0 + i] = 8'h80 + 8'(i);
    end
  end
  always @(posedge clk_sys_in) begin
    if (mem_wr_in) begin
      mem[mem_addr_in] <= mem_wdata_in;
    end
    // Outside the read slot the data toggles, so stale data never looks valid
    if (mem_rd_in) begin
      mem_rdata_out <= mem[mem_addr_in];
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule : crs_mem_model

// file: verif/test_cpu_register_set_flags.sv
// Self-checking bench for the register set via the Avalon command port.
// Assumes crs_core, its memory model and the bound checker.
`timescale 1ns/1ps
module test_cpu_register_set_flags;
  logic clk_sys_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out, mem_wr_out, mem_rd_out;
  logic [3:0] avs_address_in, irq_req_in, irq_ack_out, last_ack;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdat;
  logic [15:0] mem_addr_out, program_counter_out, ea_out;
  logic [7:0] mem_wdata_out, mem_rdata_in;
  int error_cnt, checked;

  crs_core #(.NUM_IRQ(4)) uut (.*);
  crs_mem_model u_mem (.clk_sys_in(clk_sys_in), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
    .mem_wr_in(mem_wr_out), .mem_rd_in(mem_rd_out), .mem_rdata_out(mem_rdata_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Acks last one cycle, so keep the latest one for the scenarios
  always @(posedge clk_sys_in) begin
    if (irq_ack_out != 4'h0) begin
      last_ack <= irq_ack_out;
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_sys_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus
  task automatic cmd(input crs_pkg::crs_op_t op, input logic [15:0] opnd);
    bus(1'b1, crs_pkg::REG_CMD, {11'h000, op, opnd});
  endtask : cmd
  task automatic rreg(input logic [2:0] sel);
    cmd(crs_pkg::OP_READ_REG, {13'h0000, sel});
    bus(1'b0, crs_pkg::REG_RESULT, 32'h0000_0000);
  endtask : rreg
  task automatic do_reset();
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
  endtask : do_reset

  task automatic t_reset_vals();
    rreg(3'h3);
    check("reset pc", rdat[15:0], 16'h8e8f);
    rreg(3'h2);
    check("reset sp", rdat[15:0], 16'h00ff);
    rreg(3'h4);
    check("reset flags", rdat[15:0], 16'h0068);
  endtask : t_reset_vals
  task automatic t_alu();
    crs_pkg::crs_op_t ops [8] = '{crs_pkg::OP_ADD, crs_pkg::OP_ADD, crs_pkg::OP_ADC, crs_pkg::OP_SUB,
      crs_pkg::OP_SUB, crs_pkg::OP_AND, crs_pkg::OP_SHIFT_LEFT, crs_pkg::OP_ROTATE_RIGHT};
    logic [7:0] a [8] = '{8'h7f, 8'h80, 8'h00, 8'h00, 8'h80, 8'hf0, 8'h81, 8'h02};
    logic [7:0] m [8] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'h01, 8'h0f, 8'h00, 8'h00};
    logic [7:0] r [8] = '{8'h80, 8'h00, 8'h01, 8'hff, 8'h7f, 8'h00, 8'h02, 8'h81};
    logic [7:0] f [8] = '{8'hfc, 8'heb, 8'h68, 8'h6d, 8'he8, 8'h6a, 8'he9, 8'hec};
    // Rows chain: the ADC and rotate rows rely on the carry the previous row left
    for (int i = 0; i < 8; i++) begin
      cmd(crs_pkg::OP_LOAD_ACC, {8'h00, a[i]});
      cmd(ops[i], {8'h00, m[i]});
      rreg(3'h0);
      check("acc", rdat[15:0], {8'h00, r[i]});
      rreg(3'h4);
      check("flags", rdat[15:0], {8'h00, f[i]});
    end
  endtask : t_alu
  task automatic t_stack();
    cmd(crs_pkg::OP_PUSH_ACC, 16'h0000);
    rreg(3'h2);
    check("sp push", rdat[15:0], 16'h00fe);
    check("push byte", {8'h00, u_mem.mem[16'h00ff]}, 16'h0081);
    cmd(crs_pkg::OP_LOAD_INDEX, 16'ha55a);
    cmd(crs_pkg::OP_PUSH_INDEX_UPPER, 16'h0000);
    cmd(crs_pkg::OP_PULL_ACC, 16'h0000);
    rreg(3'h0);
    check("pull acc", rdat[15:0], 16'h00a5);
    rreg(3'h2);
    check("sp pull", rdat[15:0], 16'h00fe);
    cmd(crs_pkg::OP_STACK_LOW_PRESET, 16'h0000);
    cmd(crs_pkg::OP_EA_STACK, 16'h0010);
    bus(1'b0, crs_pkg::REG_STATUS, 32'h0000_0000);
    check("stack ea", rdat[31:16], 16'h010f);
    cmd(crs_pkg::OP_EA_INDEX, 16'h0100);
    bus(1'b0, crs_pkg::REG_STATUS, 32'h0000_0000);
    check("index ea", rdat[31:16], 16'ha65a);
    check("ea port", ea_out, 16'ha65a);
  endtask : t_stack
  task automatic t_pc_map();
    cmd(crs_pkg::OP_JUMP, 16'h4000);
    cmd(crs_pkg::OP_FETCH, 16'h0000);
    rreg(3'h3);
    check("pc fetch", rdat[15:0], 16'h4001);
    cmd(crs_pkg::OP_BRANCH, 16'h0080);
    rreg(3'h3);
    check("pc port", program_counter_out, 16'h3f83);
    bus(1'b0, 4'hc, 32'h0000_0000);
    check("unmapped read", rdat[15:0], 16'h0000);
    bus(1'b1, 4'hc, 32'h0005_0011);
    rreg(3'h0);
    check("acc kept", rdat[15:0], 16'h00a5);
  endtask : t_pc_map
  task automatic t_irq();
    int n;
    n = 0;
    last_ack <= 4'h0;
    irq_req_in <= 4'b0110;
    cmd(crs_pkg::OP_LOAD_FLAGS, 16'h0000);
    repeat (20) @(posedge clk_sys_in);
    check("masked ack", {12'h000, last_ack}, 16'h0000);
    rreg(3'h4);
    check("mask kept", {15'h0000, rdat[3]}, 16'h0001);
    cmd(crs_pkg::OP_UNMASK, 16'h0000);
    while (last_ack === 4'h0 && n < 40) begin
      n++;
      @(posedge clk_sys_in);
    end
    check("ack", {12'h000, last_ack}, 16'h0002);
    irq_req_in <= 4'b0000;
    rreg(3'h3);
    check("irq vector", rdat[15:0], 16'h8889);
    rreg(3'h4);
    check("mask set", {15'h0000, rdat[3]}, 16'h0001);
    rreg(3'h2);
    check("sp stacked", rdat[15:0], 16'h00fa);
    cmd(crs_pkg::OP_RETURN_FROM_HANDLER, 16'h0000);
    rreg(3'h3);
    check("pc return", rdat[15:0], 16'h3f83);
    cmd(crs_pkg::OP_SOFT_INT, 16'h0000);
    rreg(3'h3);
    check("soft vector", rdat[15:0], 16'h8c8d);
    cmd(crs_pkg::OP_RETURN_FROM_HANDLER, 16'h0000);
    rreg(3'h4);
    check("mask return", {15'h0000, rdat[3]}, 16'h0000);
  endtask : t_irq

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    error_cnt = 0;
    checked = 0;
    resetn_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 4'h0;
    avs_writedata_in = 32'h0000_0000;
    irq_req_in = 4'h0;
    last_ack = 4'h0;
    do_reset();
    t_reset_vals();
    t_alu();
    t_stack();
    t_pc_map();
    t_irq();
    // Second reset in mid-run, after stack and flags were changed
    do_reset();
    t_reset_vals();
    tally_and_finish();
  end
endmodule : test_cpu_register_set_flags
